/* File: hdl/mbtqr_pkg.sv */
// Constants and types shared by the Modbus TCP query responder
package mbtqr_pkg;
  localparam int HDR_LEN = 6;
  localparam int BUF_DEPTH = 256;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 9;
  // Payload byte positions
  localparam int P_STA = 0;
  localparam int P_FC = 1;
  localparam int P_START = 2;
  localparam int P_QTY = 4;
  localparam int P_BCNT = 6;
  localparam int P_WDATA = 7;
  localparam logic [8:0] PLEN_FIXED = 9'h006;
  localparam logic [8:0] PLEN_MULT_MIN = 9'h007;
  // Function codes
  localparam logic [7:0] FC_RD_COIL = 8'h01;
  localparam logic [7:0] FC_RD_DISC = 8'h02;
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_INP = 8'h04;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam logic [7:0] FC_WR_REG = 8'h06;
  localparam logic [7:0] FC_WR_COILS = 8'h0f;
  localparam logic [7:0] FC_WR_REGS = 8'h10;
  localparam logic [7:0] FC_ERR_FLAG = 8'h80;
  // Exception codes
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  // Quantity limits and values
  localparam logic [15:0] MAX_RD_BITS = 16'h07d0;
  localparam logic [15:0] MAX_RD_REGS = 16'h007d;
  localparam logic [15:0] MAX_WR_BITS = 16'h07b0;
  localparam logic [15:0] MAX_WR_REGS = 16'h007b;
  localparam logic [15:0] COIL_ON = 16'hff00;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  localparam logic [7:0] STA_BCAST = 8'h00;
  localparam logic [7:0] STA_MAX = 8'hf7;
  // Reply payload lengths
  localparam logic [7:0] RLEN_EXC = 8'h03;
  localparam logic [7:0] RLEN_ECHO = 8'h06;
  localparam logic [7:0] RLEN_READ_BASE = 8'h03;
  // Reset values
  localparam logic [15:0] HREG_RST = 16'h0000;
  typedef enum logic [1:0] {
    ST_RX = 2'b00,
    ST_CHK = 2'b01,
    ST_EXE = 2'b11,
    ST_SND = 2'b10
  } mbtqr_state_t;
endpackage

/* File: hdl/mbtqr_top.sv */
// Modbus TCP query responder: frame check, decode, I/O tables and reply FIFO
// Summary of operation
// - Each frame starts with a six-byte header before station, function, data.
// - Protocol identifier and upper length byte are zero.
// - Lower length byte counts payload bytes from station address on.
// - Station address 0 is broadcast, 1 to 247 individual.
// - Function code byte follows station; 1 to 255 valid.
// - Successful reply repeats the query's function code.
// - Failed request returns function code with top bit set.
// - Supports codes 1-6, 15 and 16.
// - Coils read/write, discrete inputs, input registers read-only, holding read/write.
// - 16-bit values go high byte first.
// - 32-bit values go as two registers, low word first.
// - Data field may be empty.
// - Bit reply byte count is (points+7)/8, bits packed LSB first.
// - Failure reply is station, code with top bit, one exception byte.
// - Reply copies header bytes 0-3 and the station address.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module mbtqr_fifo
  import mbtqr_pkg::*;
#(
  parameter int W = FIFO_WIDTH,
  parameter int D = FIFO_DEPTH
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [0:D-1];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_reg != (AW + 1)'(D));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rp_reg];

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wp_reg] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_reg <= (wp_reg == AW'(D - 1)) ? '0 : wp_reg + 1'b1;
      end
      if (pop)
      begin
        rp_reg <= (rp_reg == AW'(D - 1)) ? '0 : rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module mbtqr_top
  import mbtqr_pkg::*;
#(
  parameter int N_BITS = 16,
  parameter int N_AI = 4,
  parameter int N_HREG = 8
)
(
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic [7:0] STATION_ID,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_LAST,
  output logic RX_READY,
  output logic TX_VALID,
  output logic [7:0] TX_DATA,
  output logic TX_LAST,
  input wire logic TX_READY,
  input wire logic [N_BITS-1:0] DI_IN,
  input wire logic [N_AI*32-1:0] AI_IN,
  output logic [N_BITS-1:0] COIL_OUT,
  output logic [N_HREG*16-1:0] HREG_OUT,
  output logic FRAME_DROP
);
  localparam int N_IREG = 2 * N_AI;

  mbtqr_state_t st_reg;
  mbtqr_state_t st_next;
  logic [7:0] hdr_reg [0:HDR_LEN-1];
  logic [7:0] pbuf [0:BUF_DEPTH-1];
  logic [8:0] cnt_reg;
  logic ovf_reg;
  logic drop_reg;
  logic bcast_reg;
  logic [7:0] exc_reg;
  logic [7:0] rlen_reg;
  logic [8:0] ridx_reg;
  logic [N_BITS-1:0] di_meta_reg;
  logic [N_BITS-1:0] di_reg;
  logic [N_AI*32-1:0] ai_meta_reg;
  logic [N_AI*32-1:0] ai_reg;
  logic [N_BITS-1:0] coil_reg;
  logic [N_BITS-1:0] coil_next;
  logic [15:0] hreg_reg [0:N_HREG-1];
  logic [15:0] hreg_next [0:N_HREG-1];
  logic [15:0] ireg [0:N_IREG-1];
  logic [7:0] exc_next;
  logic [7:0] rlen_next;
  logic [7:0] body_byte;
  logic [7:0] bit_byte;
  logic [7:0] tx_byte;

  ////////////////////////////////////////////////////////////////////////////
  // DI_IN and AI_IN pass two flops before use
  always_ff @(posedge CLK_SYS)
  begin
    di_meta_reg <= DI_IN;
    di_reg <= di_meta_reg;
    ai_meta_reg <= AI_IN;
    ai_reg <= ai_meta_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame capture
  wire rx_take = RX_VALID && RX_READY;
  wire [8:0] pidx = cnt_reg - 9'(HDR_LEN);
  assign RX_READY = (st_reg == ST_RX);

  always_ff @(posedge CLK_SYS)
  begin
    if (rx_take && cnt_reg >= 9'(HDR_LEN) && !pidx[8])
    begin
      pbuf[pidx[7:0]] <= RX_DATA;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      cnt_reg <= '0;
      ovf_reg <= 1'b0;
      for (int i = 0; i < HDR_LEN; i++)
      begin
        hdr_reg[i] <= 8'h00;
      end
    end
    else if (rx_take)
    begin
      if (cnt_reg < 9'(HDR_LEN))
      begin
        hdr_reg[cnt_reg[2:0]] <= RX_DATA;
      end
      // Oversize frames keep counting past the buffer and get dropped
      if (cnt_reg == 9'h1ff)
      begin
        ovf_reg <= 1'b1;
      end
      else
      begin
        cnt_reg <= cnt_reg + 9'h001;
      end
    end
    else if (st_reg == ST_EXE)
    begin
      cnt_reg <= '0;
      ovf_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Query decode
  wire [8:0] plen = pidx;
  wire [7:0] q_sta = pbuf[P_STA];
  wire [7:0] q_fc = pbuf[P_FC];
  wire [15:0] q_start = {pbuf[P_START], pbuf[P_START + 1]};
  wire [15:0] q_qty = {pbuf[P_QTY], pbuf[P_QTY + 1]};
  wire [7:0] q_bcnt = pbuf[P_BCNT];
  wire [16:0] q_end = {1'b0, q_start} + {1'b0, q_qty};
  wire [7:0] bits_bytes = 8'(({1'b0, q_qty} + 17'h00007) >> 3);
  wire is_rbit = (q_fc == FC_RD_COIL) || (q_fc == FC_RD_DISC);
  wire is_rreg = (q_fc == FC_RD_HOLD) || (q_fc == FC_RD_INP);
  wire is_single = (q_fc == FC_WR_COIL) || (q_fc == FC_WR_REG);
  wire is_mult = (q_fc == FC_WR_COILS) || (q_fc == FC_WR_REGS);
  wire hdr_bad = (hdr_reg[2] != 8'h00) || (hdr_reg[3] != 8'h00)
    || (hdr_reg[4] != 8'h00) || ({1'b0, hdr_reg[5]} != plen)
    || (cnt_reg < 9'(HDR_LEN + 2)) || ovf_reg || plen > 9'h0ff;
  wire sta_bad = (q_sta > STA_MAX) || ((q_sta != STATION_ID) && (q_sta != STA_BCAST));
  wire drop_now = hdr_bad || sta_bad || (q_fc == 8'h00);

  // Exception priority: function, then length/quantity, then address range
  always_comb
  begin
    exc_next = EXC_NONE;
    if (!(is_rbit || is_rreg || is_single || is_mult))
    begin
      exc_next = EXC_FUNC;
    end
    else if ((!is_mult && plen != PLEN_FIXED) || (is_mult && (plen < PLEN_MULT_MIN
      || plen != PLEN_MULT_MIN + {1'b0, q_bcnt})))
    begin
      exc_next = EXC_VALUE;
    end
    else
    begin
      case (q_fc)
        FC_RD_COIL, FC_RD_DISC:
        begin
          if (q_qty == 16'h0000 || q_qty > MAX_RD_BITS)
            exc_next = EXC_VALUE;
          else if (q_end > 17'(N_BITS))
            exc_next = EXC_ADDR;
        end
        FC_RD_HOLD, FC_RD_INP:
        begin
          if (q_qty == 16'h0000 || q_qty > MAX_RD_REGS)
            exc_next = EXC_VALUE;
          else if (q_end > 17'((q_fc == FC_RD_HOLD) ? N_HREG : N_IREG))
            exc_next = EXC_ADDR;
        end
        FC_WR_COIL:
        begin
          if (q_qty != COIL_ON && q_qty != COIL_OFF)
            exc_next = EXC_VALUE;
          else if ({1'b0, q_start} >= 17'(N_BITS))
            exc_next = EXC_ADDR;
        end
        FC_WR_REG:
        begin
          if ({1'b0, q_start} >= 17'(N_HREG))
            exc_next = EXC_ADDR;
        end
        FC_WR_COILS:
        begin
          if (q_qty == 16'h0000 || q_qty > MAX_WR_BITS || q_bcnt != bits_bytes)
            exc_next = EXC_VALUE;
          else if (q_end > 17'(N_BITS))
            exc_next = EXC_ADDR;
        end
        default:
        begin
          if (q_qty == 16'h0000 || q_qty > MAX_WR_REGS || q_bcnt != 8'({q_qty, 1'b0}))
            exc_next = EXC_VALUE;
          else if (q_end > 17'(N_HREG))
            exc_next = EXC_ADDR;
        end
      endcase
    end
  end

  always_comb
  begin
    if (exc_next != EXC_NONE)
      rlen_next = RLEN_EXC;
    else if (is_rbit)
      rlen_next = RLEN_READ_BASE + bits_bytes;
    else if (is_rreg)
      rlen_next = RLEN_READ_BASE + 8'({q_qty, 1'b0});
    else
      rlen_next = RLEN_ECHO;
  end

  ////////////////////////////////////////////////////////////////////////////
  // I/O tables
  wire do_write = (st_reg == ST_EXE) && !drop_reg && (exc_reg == EXC_NONE);

  genvar g;
  generate
    for (g = 0; g < N_BITS; g++)
    begin : g_coil
      wire [16:0] off = 17'(g) - {1'b0, q_start};
      wire in_rng = (17'(g) >= {1'b0, q_start}) && (17'(g) < q_end);
      wire [7:0] src = pbuf[P_WDATA + int'(off[10:3])];
      assign coil_next[g] = (do_write && q_fc == FC_WR_COIL && q_start == 16'(g))
        ? (q_qty == COIL_ON)
        : (do_write && q_fc == FC_WR_COILS && in_rng) ? src[off[2:0]] : coil_reg[g];
    end
    for (g = 0; g < N_HREG; g++)
    begin : g_hreg
      wire [16:0] off = 17'(g) - {1'b0, q_start};
      wire in_rng = (17'(g) >= {1'b0, q_start}) && (17'(g) < q_end);
      wire [8:0] bi = 9'(P_WDATA) + {off[7:0], 1'b0};
      assign hreg_next[g] = (do_write && q_fc == FC_WR_REG && q_start == 16'(g)) ? q_qty
        : (do_write && q_fc == FC_WR_REGS && in_rng)
        ? {pbuf[bi[7:0]], pbuf[8'(bi + 9'h001)]} : hreg_reg[g];
      assign HREG_OUT[g*16 +: 16] = hreg_reg[g];
    end
    for (g = 0; g < N_AI; g++)
    begin : g_ireg
      assign ireg[2*g] = ai_reg[g*32 +: 16];
      assign ireg[2*g+1] = ai_reg[g*32+16 +: 16];
    end
  endgenerate

  assign COIL_OUT = coil_reg;

  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      coil_reg <= '0;
      for (int i = 0; i < N_HREG; i++)
      begin
        hreg_reg[i] <= HREG_RST;
      end
    end
    else
    begin
      coil_reg <= coil_next;
      for (int i = 0; i < N_HREG; i++)
      begin
        hreg_reg[i] <= hreg_next[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reply byte generation
  wire [8:0] k = ridx_reg - 9'h008;
  wire [8:0] kd = k - 9'h001;
  wire [15:0] widx = q_start + 16'(kd[8:1]);
  wire [15:0] hval = (widx < 16'(N_HREG)) ? hreg_reg[widx[$clog2(N_HREG)-1:0]] : 16'h0000;
  wire [15:0] ival = (widx < 16'(N_IREG)) ? ireg[widx[$clog2(N_IREG)-1:0]] : 16'h0000;
  wire [15:0] rval = (q_fc == FC_RD_HOLD) ? hval : ival;
  wire [N_BITS-1:0] bsrc = (q_fc == FC_RD_COIL) ? coil_reg : di_reg;

  always_comb
  begin
    logic [16:0] rel;
    logic [16:0] pos;
    rel = '0;
    pos = '0;
    bit_byte = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      rel = {5'(0), kd[8:0], 3'(i)};
      pos = {1'b0, q_start} + rel;
      bit_byte[i] = (rel < {1'b0, q_qty}) && (pos < 17'(N_BITS))
        && bsrc[pos[$clog2(N_BITS)-1:0]];
    end
  end

  always_comb
  begin
    if (exc_reg != EXC_NONE)
      body_byte = exc_reg;
    else if ((is_rbit || is_rreg) && k == 9'h000)
      body_byte = rlen_reg - RLEN_READ_BASE;
    else if (is_rbit)
      body_byte = bit_byte;
    else if (is_rreg)
      body_byte = kd[0] ? rval[7:0] : rval[15:8];
    else
      body_byte = pbuf[8'(k + 9'(P_START))];
  end

  always_comb
  begin
    case (ridx_reg)
      9'h000, 9'h001, 9'h002, 9'h003: tx_byte = hdr_reg[ridx_reg[1:0]];
      9'h004: tx_byte = 8'h00;
      9'h005: tx_byte = rlen_reg;
      9'h006: tx_byte = q_sta;
      9'h007: tx_byte = (exc_reg != EXC_NONE) ? (q_fc | FC_ERR_FLAG) : q_fc;
      default: tx_byte = body_byte;
    endcase
  end

  wire snd_last = (ridx_reg == {1'b0, rlen_reg} + 9'(HDR_LEN - 1));
  wire f_ready;
  wire snd_push = (st_reg == ST_SND) && f_ready;

  mbtqr_fifo #(
    .W(FIFO_WIDTH),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .in_valid(st_reg == ST_SND),
    .in_data({snd_last, tx_byte}),
    .in_ready(f_ready),
    .out_valid(TX_VALID),
    .out_data({TX_LAST, TX_DATA}),
    .out_ready(TX_READY)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control
  always_comb
  begin
    case (st_reg)
      ST_RX: st_next = (rx_take && RX_LAST) ? ST_CHK : ST_RX;
      ST_CHK: st_next = ST_EXE;
      // Broadcasts execute but never answer
      ST_EXE: st_next = (drop_reg || bcast_reg) ? ST_RX : ST_SND;
      ST_SND: st_next = (snd_push && snd_last) ? ST_RX : ST_SND;
      default: st_next = ST_RX;
    endcase
  end

  assign FRAME_DROP = (st_reg == ST_EXE) && drop_reg;

  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      st_reg <= ST_RX;
      drop_reg <= 1'b0;
      bcast_reg <= 1'b0;
      exc_reg <= EXC_NONE;
      rlen_reg <= 8'h00;
      ridx_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
      if (st_reg == ST_CHK)
      begin
        drop_reg <= drop_now;
        bcast_reg <= (q_sta == STA_BCAST);
        exc_reg <= exc_next;
        rlen_reg <= rlen_next;
        ridx_reg <= '0;
      end
      else if (snd_push)
      begin
        ridx_reg <= ridx_reg + 9'h001;
      end
    end
  end
endmodule

/* File: bench/mbtqr_top_chk.sv */
// Port checker for the Modbus TCP query responder
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module mbtqr_top_chk
#(
  parameter int N_BITS = 16
)
(
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic RX_VALID,
  input wire logic RX_LAST,
  input wire logic RX_READY,
  input wire logic TX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_LAST,
  input wire logic TX_READY,
  input wire logic [N_BITS-1:0] COIL_OUT,
  input wire logic FRAME_DROP
);
  logic [8:0] idx_reg;
  logic [7:0] len_reg;
  wire pop = TX_VALID && TX_READY;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  // Byte position inside the reply, so header fields can be judged
  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
      idx_reg <= 9'h000;
    else if (pop)
      idx_reg <= TX_LAST ? 9'h000 : idx_reg + 9'h001;
  end
  always_ff @(posedge CLK_SYS)
  begin
    if (pop && idx_reg == 9'h005)
      len_reg <= TX_DATA;
  end
  property p_busy;
    RX_VALID && RX_READY && RX_LAST |=> !RX_READY [*2];
  endproperty
  a_busy: assert property (p_busy) else $error("ready back too soon");
  property p_drop;
    FRAME_DROP |-> !RX_READY ##1 RX_READY;
  endproperty
  a_drop: assert property (p_drop) else $error("drop timing wrong");
  property p_unsol;
    $rose(TX_VALID) |-> !RX_READY;
  endproperty
  a_unsol: assert property (p_unsol) else $error("reply outside a query");
  property p_hold;
    TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST);
  endproperty
  a_hold: assert property (p_hold) else $error("reply byte moved while stalled");
  property p_pid;
    pop && idx_reg >= 9'h002 && idx_reg <= 9'h004 |-> TX_DATA == 8'h00;
  endproperty
  a_pid: assert property (p_pid) else $error("protocol id or upper length nonzero");
  property p_len;
    pop && TX_LAST |-> idx_reg == {1'b0, len_reg} + 9'h005;
  endproperty
  a_len: assert property (p_len) else $error("length byte disagrees");
  property p_exc;
    pop && idx_reg == 9'h007 && TX_DATA[7] |-> len_reg == 8'h03;
  endproperty
  a_exc: assert property (p_exc) else $error("exception reply size wrong");
  property p_coil;
    $changed(COIL_OUT) |-> !$past(RX_READY);
  endproperty
  a_coil: assert property (p_coil) else $error("coils changed without a query");
endmodule

bind mbtqr_top mbtqr_top_chk #(.N_BITS(N_BITS)) u_chk (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
  .RX_VALID(RX_VALID), .RX_LAST(RX_LAST), .RX_READY(RX_READY), .TX_VALID(TX_VALID),
  .TX_DATA(TX_DATA), .TX_LAST(TX_LAST), .TX_READY(TX_READY), .COIL_OUT(COIL_OUT),
  .FRAME_DROP(FRAME_DROP));

/* File: bench/mbtqr_master.sv */
// Behavioural query master: sends frames and collects reply bytes
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module mbtqr_master
(
  input wire logic clk,
  input wire logic rx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  input wire logic [1:0] sink_mode
);
  logic [7:0] reply_q[$];
  int n_replies = 0;
  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
  end
  // Mode 0 accepts always, 1 every other cycle, 2 stalls
  always @(negedge clk)
    tx_ready <= (sink_mode == 2'h0) || (sink_mode == 2'h1 && !tx_ready);
  always @(posedge clk)
  begin
    if (tx_valid && tx_ready)
    begin
      reply_q.push_back(tx_data);
      n_replies += int'(tx_last);
    end
  end
  // Only this side opens a transaction; each byte holds until taken
  task automatic send(input logic [7:0] f[$]);
    for (int i = 0; i < f.size(); i++)
    begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_data = f[i];
      rx_last = (i == f.size() - 1);
      while (!rx_ready)
        @(negedge clk);
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_last = 1'b0;
    // Released bus must not keep showing the stale byte
    rx_data = ~rx_data;
  endtask
endmodule

/* File: bench/mbtqr_tb_top.sv */
// Testbench for the Modbus TCP query responder
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module mbtqr_tb_top
  import mbtqr_pkg::*;
;
  typedef logic [7:0] mbtqr_bq_t[$];
  localparam logic [7:0] STA = 8'h11;
  logic CLK_SYS = 1'b0;
  logic RSTN = 1'b0;
  logic [15:0] DI_IN = 16'h00f5;
  logic [127:0] AI_IN = {96'h0, 32'h0a0b0c0d};
  logic [1:0] mode = 2'h0;
  logic [7:0] sta_id = STA;
  logic RX_VALID, RX_LAST, RX_READY, TX_VALID, TX_LAST, TX_READY, FRAME_DROP;
  logic [7:0] RX_DATA, TX_DATA;
  logic [15:0] COIL_OUT;
  logic [127:0] HREG_OUT;
  mbtqr_bq_t none;
  int miscompares = 0;
  int n_checks = 0;
  int n_drop = 0;
  mbtqr_top dut_u (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .STATION_ID(sta_id), .RX_VALID(RX_VALID),
    .RX_DATA(RX_DATA), .RX_LAST(RX_LAST), .RX_READY(RX_READY), .TX_VALID(TX_VALID),
    .TX_DATA(TX_DATA), .TX_LAST(TX_LAST), .TX_READY(TX_READY), .DI_IN(DI_IN), .AI_IN(AI_IN),
    .COIL_OUT(COIL_OUT), .HREG_OUT(HREG_OUT), .FRAME_DROP(FRAME_DROP));
  mbtqr_master m_u (.clk(CLK_SYS), .rx_ready(RX_READY), .rx_valid(RX_VALID), .rx_data(RX_DATA),
    .rx_last(RX_LAST), .tx_valid(TX_VALID), .tx_data(TX_DATA), .tx_last(TX_LAST),
    .tx_ready(TX_READY), .sink_mode(mode));
  initial
    forever #50 CLK_SYS = ~CLK_SYS;
  always @(negedge CLK_SYS)
    if (FRAME_DROP === 1'b1)
      n_drop++;
////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (miscompares == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  function automatic mbtqr_bq_t frm(input logic [7:0] tid, input mbtqr_bq_t p);
    return {8'h00, tid, 8'h00, 8'h00, 8'h00, 8'(p.size()), p};
  endfunction
  // Sends a query and compares the whole reply; an empty r means no reply
  task automatic xact(input mbtqr_bq_t q, input mbtqr_bq_t r, input int drops);
    mbtqr_bq_t e;
    int n;
    int d;
    n = m_u.n_replies;
    d = n_drop;
    m_u.reply_q.delete();
    m_u.send(q);
    if (r.size() == 0)
      repeat (30) @(negedge CLK_SYS);
    for (int i = 0; i < 600 && m_u.n_replies == n && r.size() > 0; i++)
      @(negedge CLK_SYS);
    if (r.size() > 0)
      e = frm(q[1], r);
    check(16'(m_u.reply_q.size()), 16'(e.size()));
    foreach (e[i])
      check(16'(m_u.reply_q[i]), 16'(e[i]));
    check(16'(n_drop - d), 16'(drops));
  endtask
////////////////////////////////////////////////////////////////////////////////
  task automatic sc_coils;
    xact(frm(8'h01, '{STA, FC_WR_COILS, 8'h00, 8'h00, 8'h00, 8'h10, 8'h02, 8'h03, 8'ha5}),
      '{STA, FC_WR_COILS, 8'h00, 8'h00, 8'h00, 8'h10}, 0);
    check(COIL_OUT, 16'ha503);
    xact(frm(8'h02, '{STA, FC_RD_COIL, 8'h00, 8'h00, 8'h00, 8'h02}),
      '{STA, FC_RD_COIL, 8'h01, 8'h03}, 0);
    xact(frm(8'h03, '{STA, FC_RD_COIL, 8'h00, 8'h03, 8'h00, 8'h0a}),
      '{STA, FC_RD_COIL, 8'h02, 8'ha0, 8'h00}, 0);
    xact(frm(8'h04, '{STA, FC_WR_COIL, 8'h00, 8'h0f, 8'h00, 8'h00}),
      '{STA, FC_WR_COIL, 8'h00, 8'h0f, 8'h00, 8'h00}, 0);
    xact(frm(8'h05, '{8'h00, FC_WR_COIL, 8'h00, 8'h02, 8'hff, 8'h00}), none, 0);
    check(COIL_OUT, 16'h2507);
  endtask
  task automatic sc_regs;
    mbtqr_bq_t w;
    mbtqr_bq_t rd;
    w = '{STA, FC_WR_REGS, 8'h00, 8'h00, 8'h00, 8'h08, 8'h10};
    rd = '{STA, FC_RD_HOLD, 8'h10};
    for (int i = 0; i < 8; i++)
    begin
      w.push_back(8'ha0 + 8'(i));
      w.push_back(8'h50 + 8'(i));
      rd.push_back(8'ha0 + 8'(i));
      rd.push_back(8'h50 + 8'(i));
    end
    xact(frm(8'h06, w), '{STA, FC_WR_REGS, 8'h00, 8'h00, 8'h00, 8'h08}, 0);
    for (int i = 0; i < 8; i++)
      check(HREG_OUT[16*i +: 16], {8'ha0 + 8'(i), 8'h50 + 8'(i)});
    // Reply is longer than the FIFO, so a stalled sink must hold the query side off
    mode = 2'h2;
    fork
      xact(frm(8'h07, '{STA, FC_RD_HOLD, 8'h00, 8'h00, 8'h00, 8'h08}), rd, 0);
      begin
        repeat (60) @(negedge CLK_SYS);
        check(16'(RX_READY), 16'h0000);
        check(16'(TX_VALID), 16'h0001);
        mode = 2'h1;
      end
    join
    mode = 2'h0;
    xact(frm(8'h08, '{STA, FC_WR_REG, 8'h00, 8'h02, 8'h0a, 8'h0b}),
      '{STA, FC_WR_REG, 8'h00, 8'h02, 8'h0a, 8'h0b}, 0);
    check(HREG_OUT[47:32], 16'h0a0b);
    xact(frm(8'h09, '{STA, FC_RD_INP, 8'h00, 8'h00, 8'h00, 8'h02}),
      '{STA, FC_RD_INP, 8'h04, 8'h0c, 8'h0d, 8'h0a, 8'h0b}, 0);
    xact(frm(8'h0a, '{STA, FC_RD_DISC, 8'h00, 8'h00, 8'h00, 8'h08}),
      '{STA, FC_RD_DISC, 8'h01, 8'hf5}, 0);
  endtask
  task automatic sc_errs;
    xact(frm(8'h0b, '{STA, 8'h07}), '{STA, 8'h87, EXC_FUNC}, 0);
    xact(frm(8'h0c, '{STA, FC_RD_COIL, 8'h00, 8'h00, 8'h00, 8'h00}),
      '{STA, 8'h81, EXC_VALUE}, 0);
    xact(frm(8'h0d, '{STA, FC_RD_COIL, 8'h00, 8'h0f, 8'h00, 8'h02}),
      '{STA, 8'h81, EXC_ADDR}, 0);
  endtask
  task automatic sc_drop;
    mbtqr_bq_t big;
    // Oversize frame saturates the byte counter and must vanish without a reply
    for (int i = 0; i < 520; i++)
      big.push_back(8'h00);
    xact(big, none, 1);
    xact('{8'h00, 8'h0e, 8'h00, 8'h01, 8'h00, 8'h06, STA, 8'h01, 8'h00, 8'h00, 8'h00, 8'h02},
      none, 1);
    xact('{8'h00, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h07, STA, 8'h01, 8'h00, 8'h00, 8'h00, 8'h02},
      none, 1);
    xact(frm(8'h10, '{8'hf8, 8'h01, 8'h00, 8'h00, 8'h00, 8'h02}), none, 1);
    xact(frm(8'h11, '{8'h12, 8'h01, 8'h00, 8'h00, 8'h00, 8'h02}), none, 1);
    xact(frm(8'h12, '{STA, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02}), none, 1);
    // The station input must steer which address is answered
    sta_id = 8'h12;
    xact(frm(8'h13, '{8'h12, FC_RD_DISC, 8'h00, 8'h00, 8'h00, 8'h08}),
      '{8'h12, FC_RD_DISC, 8'h01, 8'hf5}, 0);
    xact(frm(8'h14, '{STA, FC_RD_DISC, 8'h00, 8'h00, 8'h00, 8'h08}), none, 1);
    sta_id = STA;
  endtask
////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(negedge CLK_SYS);
    RSTN = 1'b1;
    sc_coils();
    sc_regs();
    sc_errs();
    sc_drop();
    end_of_test();
  end
  // 21 queries, most under 100 cycles and the 520-byte one near 550, fit well inside this span
  initial
  begin
    repeat (8000) @(posedge CLK_SYS);
    miscompares++;
    end_of_test();
  end
endmodule
